// ===== logic/clock_synth_control_regs.sv
// How it works
// - Byte 4 bit 7 reads highest frequency strap latched when power good asserts.
// - Byte 4 bit 6 tri-states the 96 MHz video pair in sleep; resets 0.
// - Byte 4 bits 3..5 make free bus clocks stoppable by software stop.
// - Byte 5 bit 7 tri-states stopped serial reference pairs during software stop.
// - Byte 5 bit 3 tri-states all serial reference pairs during power down.
// - Byte 5 bits 1,0 tri-state processor pairs 1,0 during power down.
// - Byte 6 bit 6 enters test clock mode.
// - Byte 6 bit 7 picks tri-state or divided crystal in test mode.
// - Byte 6 bit 5 reads fourth frequency strap latched at power good.
// - Byte 6 bits 2..0 read third, second, first straps latched at power good.
// - Byte 6 bit 4 sets crystal copy drive, 1 low strength, resets 1.
// - Byte 6 bit 3 zero stops bus clocks, one releases; resets one.
// - Byte 8 bit 7 selects processor spread amount 0.5 or 1.0 percent.
// - Byte 8 bit 6 selects processor down or center spread.
// - Byte 8 bit 5 set turns serial reference spread on; resets 0.
// - Byte 8 bit 4 selects serial reference spread amount.
// - Byte 8 bits 2,1 set 48 MHz and 33 MHz drive; resets 1.
// - Byte 9 bits 3..0 hold software frequency select; upper bits reserved.
// - Single byte reads and writes selected by command code from the bus engine.
`timescale 1ns/1ps
module clock_synth_control_regs
  import clk_synth_regs_pkg::*;
#(
  parameter int BUS33_LANES = 6,
  parameter int SRC_LANES = 5,
  // Arbitrary identification values
  parameter logic [3:0] REVISION_CODE = 4'h3,
  parameter logic [3:0] VENDOR_CODE = 4'h5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Byte port from the serial protocol engine
  input wire logic [7:0] cmd_code,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  output logic rd_hit,
  // Pins
  input wire logic [4:0] freq_strap_pins,
  input wire logic power_good_n,
  input wire logic power_down_input,
  // Clock levels from the synthesizers and stop permissions held elsewhere
  input wire logic [BUS33_LANES-1:0] bus33_phase,
  input wire logic [2:0] free_bus_phase,
  input wire logic [SRC_LANES-1:0] serial_ref_phase,
  input wire logic [SRC_LANES-1:0] serial_ref_stoppable,
  // Gated clock levels
  output logic [BUS33_LANES-1:0] bus33_clk,
  output logic [2:0] free_bus_clk,
  output logic [SRC_LANES-1:0] serial_ref_clk,
  // Output drive states
  output logic video_96m_pair_tristate,
  output logic [SRC_LANES-1:0] serial_ref_clock_pair_tristate,
  output logic [1:0] cpu_pair_tristate,
  output logic sleep_state,
  output logic bus_clock_halt_n,
  // Test and drive strength
  output logic test_mode,
  output logic test_ref_divided,
  output logic ref_drive_low,
  output logic usb48_drive_single,
  output logic bus33_drive_single,
  // Spread and frequency selection
  output logic processor_spread_wide,
  output logic processor_spread_type,
  output logic serial_ref_spread_on,
  output logic serial_ref_spread_amount,
  output logic [3:0] soft_freq_sel,
  output logic [4:0] freq_strap_latched
);

  // Writable storage
  logic [6:0] strap_and_free_clock_stop_cfg;
  logic [7:0] stop_and_powerdown_drive_cfg;
  logic [7:0] test_and_soft_stop_ctrl;
  logic [7:0] spread_and_drive_cfg;
  logic [3:0] soft_frequency_select;

  // Strap latches
  logic freq_strap_high_latch;
  logic freq_strap_d_latch;
  logic freq_strap_c_latch;
  logic freq_strap_b_latch;
  logic freq_strap_a_latch;

  // Pin synchroniser: three stages, change taken once stages two and three agree
  logic [PIN_LANES-1:0] pin_s1;
  logic [PIN_LANES-1:0] pin_s2;
  logic [PIN_LANES-1:0] pin_s3;
  logic [PIN_LANES-1:0] pin_clean;
  logic pg_clean_d;

  wire [PIN_LANES-1:0] pin_raw = {power_good_n, power_down_input, freq_strap_pins};
  wire [PIN_LANES-1:0] pin_agree = ~(pin_s2 ^ pin_s3);
  wire [PIN_LANES-1:0] next_pin_clean = (pin_agree & pin_s3) | (~pin_agree & pin_clean);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // A one-cycle disagreement between stages two and three is held off,
  // so a bouncing pin costs latency rather than a false edge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_clean <= '0;
    end else begin
      pin_clean <= next_pin_clean;
    end
  end

  // Power good is active low; its assertion is the falling edge of the clean level.
  // Reset clears the latches; only a later power-good assertion loads them.
  // The delayed level starts low, so a pin already high at reset gives no false edge.
  wire pg_assert = pg_clean_d & ~pin_clean[LANE_PG];
  wire pd_active = pin_clean[LANE_PD];

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pg_clean_d <= 1'b0;
    end else begin
      pg_clean_d <= pin_clean[LANE_PG];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      freq_strap_high_latch <= 1'b0;
      freq_strap_d_latch <= 1'b0;
      freq_strap_c_latch <= 1'b0;
      freq_strap_b_latch <= 1'b0;
      freq_strap_a_latch <= 1'b0;
    end else if (pg_assert) begin
      freq_strap_high_latch <= pin_clean[4];
      freq_strap_d_latch <= pin_clean[3];
      freq_strap_c_latch <= pin_clean[2];
      freq_strap_b_latch <= pin_clean[1];
      freq_strap_a_latch <= pin_clean[0];
    end
  end

  // Address decode
  // Exact compares keep codes outside the bank from aliasing onto it
  wire hit_b4 = (cmd_code == OFS_STRAP_FREE_STOP);
  wire hit_b5 = (cmd_code == OFS_STOP_PD_DRIVE);
  wire hit_b6 = (cmd_code == OFS_TEST_SOFT_STOP);
  wire hit_b7 = (cmd_code == OFS_IDENT);
  wire hit_b8 = (cmd_code == OFS_SPREAD_DRIVE);
  wire hit_b9 = (cmd_code == OFS_SOFT_FREQ);
  wire hit_any = hit_b4 | hit_b5 | hit_b6 | hit_b7 | hit_b8 | hit_b9;

  // Byte images as read back
  wire [7:0] image_b4 = {freq_strap_high_latch, strap_and_free_clock_stop_cfg};
  wire [7:0] image_b6 = (test_and_soft_stop_ctrl & B6_WR_MASK)
                      | {2'b00, freq_strap_d_latch, 2'b00,
                         freq_strap_c_latch, freq_strap_b_latch, freq_strap_a_latch};
  // Identification is fixed; a write to its code changes nothing
  wire [7:0] image_b7 = {REVISION_CODE, VENDOR_CODE};
  wire [7:0] image_b9 = {4'h0, soft_frequency_select};

  wire [7:0] read_mux =
      hit_b4 ? image_b4 :
      hit_b5 ? stop_and_powerdown_drive_cfg :
      hit_b6 ? image_b6 :
      hit_b7 ? image_b7 :
      hit_b8 ? spread_and_drive_cfg :
      hit_b9 ? image_b9 : 8'h00;

  // Register writes; strap copies and identification ignore writes.
  // Reserved bits store what is written, except byte 9 bits 7..4, which are not stored and read 0.
  wire wr_b4 = wr_stb & hit_b4;
  wire wr_b5 = wr_stb & hit_b5;
  wire wr_b6 = wr_stb & hit_b6;
  wire wr_b8 = wr_stb & hit_b8;
  wire wr_b9 = wr_stb & hit_b9;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_and_free_clock_stop_cfg <= B4_RESET;
    end else if (wr_b4) begin
      strap_and_free_clock_stop_cfg <= wr_data[6:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_and_powerdown_drive_cfg <= B5_RESET;
    end else if (wr_b5) begin
      stop_and_powerdown_drive_cfg <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_and_soft_stop_ctrl <= B6_RESET;
    end else if (wr_b6) begin
      test_and_soft_stop_ctrl <= wr_data & B6_WR_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      spread_and_drive_cfg <= B8_RESET;
    end else if (wr_b8) begin
      spread_and_drive_cfg <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_frequency_select <= B9_RESET;
    end else if (wr_b9) begin
      soft_frequency_select <= wr_data[3:0];
    end
  end

  // Read port: data registered on the strobe, held until the next read.
  // The hit flag lets the protocol engine refuse codes outside the bank.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_stb) begin
      rd_data <= read_mux;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_hit <= 1'b0;
    end else if (rd_stb) begin
      rd_hit <= hit_any;
    end
  end

  // Software stop: bit clear means stop asserted
  wire soft_stop = ~test_and_soft_stop_ctrl[B6_SOFT_RUN];
  wire [2:0] free_stoppable =
      strap_and_free_clock_stop_cfg[B4_FREE_STOP_LO +: 3];

  // One sequencer for all stoppable lanes keeps their halts aligned.
  // Plain 33 MHz outputs are always stoppable; the others only when allowed.
  localparam int ALL_LANES = BUS33_LANES + 3 + SRC_LANES;
  wire [ALL_LANES-1:0] lane_phase = {serial_ref_phase, free_bus_phase, bus33_phase};
  wire [ALL_LANES-1:0] lane_stop =
      {serial_ref_stoppable & {SRC_LANES{soft_stop}},
       free_stoppable & {3{soft_stop}},
       {BUS33_LANES{soft_stop}}};
  logic [ALL_LANES-1:0] lane_gated;
  logic [ALL_LANES-1:0] lane_halted;

  glitchless_stop #(
    .LANES(ALL_LANES)
  ) u_stop (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .phase(lane_phase),
    .stop_req(lane_stop),
    .gated(lane_gated),
    .halted(lane_halted)
  );

  // Lane order in the sequencer: 33 MHz, free bus, then serial reference
  assign bus33_clk = lane_gated[BUS33_LANES-1:0];
  assign free_bus_clk = lane_gated[BUS33_LANES +: 3];
  assign serial_ref_clk = lane_gated[BUS33_LANES + 3 +: SRC_LANES];
  wire [SRC_LANES-1:0] src_halted = lane_halted[BUS33_LANES + 3 +: SRC_LANES];

  // Drive-state decode
  wire next_video_tri =
      pd_active & strap_and_free_clock_stop_cfg[B4_VIDEO_SLEEP];
  wire [SRC_LANES-1:0] next_src_tri =
      ({SRC_LANES{pd_active & stop_and_powerdown_drive_cfg[B5_SRC_PD_TRI]}})
      | (src_halted & {SRC_LANES{stop_and_powerdown_drive_cfg[B5_SRC_STOP_TRI]}});
  wire [1:0] next_cpu_tri =
      {pd_active & stop_and_powerdown_drive_cfg[B5_CPU1_PD_TRI],
       pd_active & stop_and_powerdown_drive_cfg[B5_CPU0_PD_TRI]};

  // Registered drive states: one flop of delay buys glitch-free pad controls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      video_96m_pair_tristate <= 1'b0;
    end else begin
      video_96m_pair_tristate <= next_video_tri;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_ref_clock_pair_tristate <= '0;
    end else begin
      serial_ref_clock_pair_tristate <= next_src_tri;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_pair_tristate <= 2'b00;
    end else begin
      cpu_pair_tristate <= next_cpu_tri;
    end
  end

  // Sleep status lags the clean pin by the same flop as the pad controls
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_state <= 1'b0;
    end else begin
      sleep_state <= pd_active;
    end
  end

  // Static controls straight from storage
  assign bus_clock_halt_n = ~soft_stop;
  assign test_mode = test_and_soft_stop_ctrl[B6_TEST_MODE];
  assign test_ref_divided = test_and_soft_stop_ctrl[B6_TEST_SEL];
  assign ref_drive_low = test_and_soft_stop_ctrl[B6_REF_WEAK];
  assign processor_spread_wide = spread_and_drive_cfg[B8_CPU_SS_WIDE];
  assign processor_spread_type = spread_and_drive_cfg[B8_CPU_SS_TYPE];
  assign serial_ref_spread_on = spread_and_drive_cfg[B8_SERIAL_REF_SPREAD_AMOUNT_ON];
  assign serial_ref_spread_amount = spread_and_drive_cfg[B8_SERIAL_REF_SPREAD_AMOUNT_WIDE];
  assign usb48_drive_single = spread_and_drive_cfg[B8_USB_SINGLE];
  assign bus33_drive_single = spread_and_drive_cfg[B8_BUS33_SINGLE];
  assign soft_freq_sel = soft_frequency_select;
  assign freq_strap_latched = {freq_strap_high_latch, freq_strap_d_latch,
                               freq_strap_c_latch, freq_strap_b_latch,
                               freq_strap_a_latch};

endmodule : clock_synth_control_regs

// ===== inc/clk_synth_regs_pkg.sv
package clk_synth_regs_pkg;

  // Command codes that select each control byte
  localparam logic [7:0] OFS_STRAP_FREE_STOP = 8'h04;
  localparam logic [7:0] OFS_STOP_PD_DRIVE = 8'h05;
  localparam logic [7:0] OFS_TEST_SOFT_STOP = 8'h06;
  localparam logic [7:0] OFS_IDENT = 8'h07;
  localparam logic [7:0] OFS_SPREAD_DRIVE = 8'h08;
  localparam logic [7:0] OFS_SOFT_FREQ = 8'h09;

  // Byte 0x04 fields
  localparam int B4_STRAP_E = 7;
  localparam int B4_VIDEO_SLEEP = 6;
  localparam int B4_FREE_STOP_LO = 3;
  localparam logic [6:0] B4_RESET = 7'h07;

  // Byte 0x05 fields
  localparam int B5_SRC_STOP_TRI = 7;
  localparam int B5_SRC_PD_TRI = 3;
  localparam int B5_CPU1_PD_TRI = 1;
  localparam int B5_CPU0_PD_TRI = 0;
  localparam logic [7:0] B5_RESET = 8'h00;

  // Byte 0x06 fields; bits 5 and 2..0 are strap copies
  localparam int B6_TEST_SEL = 7;
  localparam int B6_TEST_MODE = 6;
  localparam int B6_STRAP_D = 5;
  localparam int B6_REF_WEAK = 4;
  localparam int B6_SOFT_RUN = 3;
  localparam logic [7:0] B6_WR_MASK = 8'hD8;
  localparam logic [7:0] B6_RESET = 8'h18;

  // Byte 0x08 fields
  localparam int B8_CPU_SS_WIDE = 7;
  localparam int B8_CPU_SS_TYPE = 6;
  localparam int B8_SERIAL_REF_SPREAD_AMOUNT_ON = 5;
  localparam int B8_SERIAL_REF_SPREAD_AMOUNT_WIDE = 4;
  localparam int B8_USB_SINGLE = 2;
  localparam int B8_BUS33_SINGLE = 1;
  localparam logic [7:0] B8_RESET = 8'h06;

  // Byte 0x09 field
  localparam logic [3:0] B9_RESET = 4'h0;

  // Pin synchroniser lanes
  localparam int PIN_LANES = 7;
  localparam int LANE_PD = 5;
  localparam int LANE_PG = 6;

endpackage : clk_synth_regs_pkg

// ===== logic/glitchless_stop.sv
`timescale 1ns/1ps
module glitchless_stop #(
  parameter int LANES = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Per-lane clock level and stop request
  input wire logic [LANES-1:0] phase,
  input wire logic [LANES-1:0] stop_req,
  // Gated clock level and halted status
  output logic [LANES-1:0] gated,
  output logic [LANES-1:0] halted
);

  logic [LANES-1:0] running;

  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      // Run state may only change while the clock is low, so a high
      // phase is never cut short on stop nor started mid-way on resume.
      wire next_run = phase[i] ? running[i] : ~stop_req[i];
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          running[i] <= 1'b1;
          gated[i] <= 1'b0;
        end else begin
          running[i] <= next_run;
          gated[i] <= phase[i] & next_run;
        end
      end
      assign halted[i] = ~running[i];
    end
  endgenerate

endmodule : glitchless_stop

// ===== tb/clock_synth_control_regs_chk.sv
`timescale 1ns/1ps
module clock_synth_control_regs_chk
  import clk_synth_regs_pkg::*;
#(
  parameter int SRC_LANES = 5,
  parameter logic [3:0] REVISION_CODE = 4'h3,
  parameter logic [3:0] VENDOR_CODE = 4'h5
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Byte port
  input wire logic [7:0] cmd_code,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic rd_stb,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit,
  // Pins and lanes
  input wire logic power_down_input,
  input wire logic [SRC_LANES-1:0] serial_ref_phase,
  input wire logic [SRC_LANES-1:0] serial_ref_stoppable,
  input wire logic [SRC_LANES-1:0] serial_ref_clk,
  // Register outputs
  input wire logic sleep_state,
  input wire logic bus_clock_halt_n,
  input wire logic test_mode,
  input wire logic test_ref_divided,
  input wire logic processor_spread_wide,
  input wire logic processor_spread_type,
  input wire logic serial_ref_spread_on,
  input wire logic serial_ref_spread_amount,
  input wire logic [3:0] soft_freq_sel,
  input wire logic [4:0] freq_strap_latched
);
  logic [7:0] wr_data_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge core_clk) begin
    wr_data_q <= wr_data;
  end
  halt_follow_a: assert property (wr_stb && cmd_code == OFS_TEST_SOFT_STOP |=>
    bus_clock_halt_n == wr_data_q[3]) else $error("software stop level wrong");
  test_sel_a: assert property (wr_stb && cmd_code == OFS_TEST_SOFT_STOP |=>
    {test_ref_divided, test_mode} == wr_data_q[7:6]) else $error("test mode wrong");
  spread_cfg_a: assert property (wr_stb && cmd_code == OFS_SPREAD_DRIVE |=>
    {processor_spread_wide, processor_spread_type, serial_ref_spread_on,
    serial_ref_spread_amount} == wr_data_q[7:4]) else $error("spread outputs wrong");
  freq_sel_a: assert property (wr_stb && cmd_code == OFS_SOFT_FREQ |=>
    soft_freq_sel == wr_data_q[3:0]) else $error("soft frequency select wrong");
  ident_read_a: assert property (rd_stb && cmd_code == OFS_IDENT |=>
    rd_hit && rd_data == {REVISION_CODE, VENDOR_CODE}) else $error("ident byte wrong");
  miss_read_a: assert property (rd_stb && (cmd_code < OFS_STRAP_FREE_STOP ||
    cmd_code > OFS_SOFT_FREQ) |=> !rd_hit && rd_data == 8'h00) else $error("miss read wrong");
  strap_low_a: assert property (rd_stb && cmd_code == OFS_TEST_SOFT_STOP |=>
    {rd_data[5], rd_data[2:0]} == freq_strap_latched[3:0]) else $error("strap copy wrong");
  strap_high_a: assert property (rd_stb && cmd_code == OFS_STRAP_FREE_STOP |=>
    rd_data[7] == freq_strap_latched[4]) else $error("high strap copy wrong");
  free_lane_a: assert property (!serial_ref_stoppable[0] |=>
    serial_ref_clk[0] == $past(serial_ref_phase[0])) else $error("free lane stopped");
  pd_seen_a: assert property (power_down_input |-> ##[1:6] sleep_state)
    else $error("power down not seen");
endmodule : clock_synth_control_regs_chk

bind clock_synth_control_regs clock_synth_control_regs_chk #(.SRC_LANES(SRC_LANES),
  .REVISION_CODE(REVISION_CODE), .VENDOR_CODE(VENDOR_CODE)) i_chk (.core_clk(core_clk),
  .rst_n(rst_n), .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
  .rd_data(rd_data), .rd_hit(rd_hit), .power_down_input(power_down_input),
  .serial_ref_phase(serial_ref_phase), .serial_ref_stoppable(serial_ref_stoppable),
  .serial_ref_clk(serial_ref_clk), .sleep_state(sleep_state),
  .bus_clock_halt_n(bus_clock_halt_n), .test_mode(test_mode),
  .test_ref_divided(test_ref_divided), .processor_spread_wide(processor_spread_wide),
  .processor_spread_type(processor_spread_type), .serial_ref_spread_on(serial_ref_spread_on),
  .serial_ref_spread_amount(serial_ref_spread_amount), .soft_freq_sel(soft_freq_sel),
  .freq_strap_latched(freq_strap_latched));

// ===== tb/smbus_byte_host.sv
`timescale 1ns/1ps
module smbus_byte_host (
  // Clock
  input wire logic core_clk,
  // Byte port toward the register bank
  output logic [7:0] cmd_code,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic rd_stb,
  input wire logic [7:0] rd_data,
  input wire logic rd_hit
);
  initial begin
    cmd_code = 8'h00;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    rd_stb = 1'b0;
  end
  // Single-byte write: command code selects the byte, data rides the same strobe
  task automatic put(input logic [7:0] code, input logic [7:0] data);
    @(negedge core_clk);
    cmd_code = code;
    wr_data = data;
    wr_stb = 1'b1;
    @(negedge core_clk);
    wr_stb = 1'b0;
    // Released data carries no stale copy
    wr_data = ~data;
  endtask : put
  task automatic get(input logic [7:0] code, output logic [7:0] data, output logic hit);
    @(negedge core_clk);
    cmd_code = code;
    rd_stb = 1'b1;
    @(negedge core_clk);
    rd_stb = 1'b0;
    data = rd_data;
    hit = rd_hit;
  endtask : get
endmodule : smbus_byte_host

// ===== tb/clock_synth_control_regs_bench.sv
`timescale 1ns/1ps
module clock_synth_control_regs_bench;
  import clk_synth_regs_pkg::*;
  // Arbitrary identification values
  localparam logic [7:0] ID_EXP = 8'h35;
  logic core_clk, rst_n, wr_stb, rd_stb, rd_hit, power_good_n, power_down_input, ph;
  logic [7:0] cmd_code, wr_data, rd_data;
  logic [4:0] freq_strap_pins, serial_ref_stoppable, serial_ref_clk, src_tri, straps;
  logic [5:0] bus33_clk;
  logic [2:0] free_bus_clk;
  logic [1:0] cpu_tri;
  logic [3:0] soft_freq_sel;
  logic video_tri, sleep_state, halt_n, tmode, tdiv, ref_low, usb_single, b33_single;
  logic ss_wide, ss_type, serial_ref_spread_amount_on, serial_ref_spread_amount_amt;
  int mismatches, total_checks, cycles;
  clock_synth_control_regs #(.REVISION_CODE(ID_EXP[7:4]), .VENDOR_CODE(ID_EXP[3:0])) i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .cmd_code(cmd_code), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_hit(rd_hit),
    .freq_strap_pins(freq_strap_pins), .power_good_n(power_good_n),
    .power_down_input(power_down_input), .bus33_phase({6{ph}}), .free_bus_phase({3{ph}}),
    .serial_ref_phase({5{ph}}), .serial_ref_stoppable(serial_ref_stoppable),
    .bus33_clk(bus33_clk), .free_bus_clk(free_bus_clk), .serial_ref_clk(serial_ref_clk),
    .video_96m_pair_tristate(video_tri), .serial_ref_clock_pair_tristate(src_tri),
    .cpu_pair_tristate(cpu_tri), .sleep_state(sleep_state), .bus_clock_halt_n(halt_n),
    .test_mode(tmode), .test_ref_divided(tdiv), .ref_drive_low(ref_low),
    .usb48_drive_single(usb_single), .bus33_drive_single(b33_single),
    .processor_spread_wide(ss_wide), .processor_spread_type(ss_type),
    .serial_ref_spread_on(serial_ref_spread_amount_on), .serial_ref_spread_amount(serial_ref_spread_amount_amt),
    .soft_freq_sel(soft_freq_sel), .freq_strap_latched(straps));
  smbus_byte_host i_host (.core_clk(core_clk), .cmd_code(cmd_code), .wr_stb(wr_stb),
    .wr_data(wr_data), .rd_stb(rd_stb), .rd_data(rd_data), .rd_hit(rd_hit));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // One shared lane phase toggling every cycle keeps sample counts exact
  always @(negedge core_clk) begin
    ph <= ~ph;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done;
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp, input logic hit_exp);
    logic [7:0] d;
    logic h;
    i_host.get(code, d, h);
    chk(d, exp);
    chk({7'h00, h}, {7'h00, hit_exp});
  endtask : rd_chk
  task automatic t_reset_and_map;
    logic [7:0] exp [6] = '{8'h07, 8'h00, 8'h18, ID_EXP, 8'h06, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(i + 4), exp[i], 1'b1);
    end
    rd_chk(8'h03, 8'h00, 1'b0);
    rd_chk(8'h0A, 8'h00, 1'b0);
  endtask : t_reset_and_map
  // Reserved bits written as the host must: byte 4 low bits 1, bytes 5 and 8 reserved 0
  task automatic t_write_back(input logic [7:0] wv [6], input logic [7:0] rv [6]);
    for (int i = 0; i < 6; i++) begin
      i_host.put(8'(i + 4), wv[i]);
    end
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(i + 4), rv[i], 1'b1);
    end
  endtask : t_write_back
  task automatic t_fields;
    t_write_back('{8'h7F, 8'h8B, 8'hFF, 8'hAA, 8'hF6, 8'hFF},
      '{8'h7F, 8'h8B, 8'hD8, ID_EXP, 8'hF6, 8'h0F});
    chk({tmode, tdiv, ref_low, usb_single, b33_single, ss_wide, ss_type, serial_ref_spread_amount_on}, 8'hFF);
    chk({serial_ref_spread_amount_amt, halt_n, 2'b00, soft_freq_sel}, 8'hCF);
    t_write_back('{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
      '{8'h07, 8'h00, 8'h00, ID_EXP, 8'h00, 8'h00});
    chk({tmode, tdiv, ref_low, usb_single, b33_single, ss_wide, ss_type, serial_ref_spread_amount_on}, 8'h00);
    chk({serial_ref_spread_amount_amt, halt_n, 2'b00, soft_freq_sel}, 8'h00);
    i_host.put(OFS_TEST_SOFT_STOP, 8'h18);
  endtask : t_fields
  task automatic t_straps;
    freq_strap_pins = 5'b10110;
    repeat (6) @(negedge core_clk);
    power_good_n = 1'b0;
    repeat (8) @(negedge core_clk);
    chk({3'b000, straps}, 8'h16);
    rd_chk(OFS_STRAP_FREE_STOP, 8'h87, 1'b1);
    rd_chk(OFS_TEST_SOFT_STOP, 8'h1E, 1'b1);
    freq_strap_pins = 5'b01001;
    repeat (8) @(negedge core_clk);
    chk({3'b000, straps}, 8'h16);
  endtask : t_straps
  // Counts highs of a lane over six cycles; a stopped lane gives 0, a running one 3
  task automatic t_stop;
    int hi_free, hi_stop;
    serial_ref_stoppable = 5'b00001;
    i_host.put(OFS_STRAP_FREE_STOP, 8'h0F);
    i_host.put(OFS_STOP_PD_DRIVE, 8'h80);
    for (int k = 0; k < 2; k++) begin
      i_host.put(OFS_TEST_SOFT_STOP, k ? 8'h18 : 8'h10);
      repeat (4) @(negedge core_clk);
      hi_free = 0;
      hi_stop = 0;
      for (int c = 0; c < 6; c++) begin
        @(negedge core_clk);
        hi_free += free_bus_clk[1] + free_bus_clk[2] + serial_ref_clk[1];
        hi_stop += free_bus_clk[0] + serial_ref_clk[0] + bus33_clk[0];
      end
      chk(8'(hi_free), 8'd9);
      chk(8'(hi_stop), k ? 8'd9 : 8'd0);
      chk({3'b000, src_tri}, k ? 8'h00 : 8'h01);
    end
  endtask : t_stop
  task automatic t_power_down;
    i_host.put(OFS_STRAP_FREE_STOP, 8'h47);
    i_host.put(OFS_STOP_PD_DRIVE, 8'h0B);
    power_down_input = 1'b1;
    repeat (8) @(negedge core_clk);
    chk({video_tri, cpu_tri, src_tri}, 8'hFF);
    i_host.put(OFS_STRAP_FREE_STOP, 8'h07);
    i_host.put(OFS_STOP_PD_DRIVE, 8'h00);
    repeat (3) @(negedge core_clk);
    chk({sleep_state, video_tri, cpu_tri, 4'h0}, 8'h80);
    chk({3'b000, src_tri}, 8'h00);
    power_down_input = 1'b0;
  endtask : t_power_down
  initial begin
    rst_n = 1'b0;
    ph = 1'b0;
    power_good_n = 1'b1;
    power_down_input = 1'b0;
    freq_strap_pins = 5'b00000;
    serial_ref_stoppable = 5'b00000;
    repeat (2) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset_and_map();
    t_fields();
    t_straps();
    t_stop();
    t_power_down();
    test_done();
  end
endmodule : clock_synth_control_regs_bench
